// ===== hw/umfs_pkg.sv
package umfs_pkg;
  localparam logic [31:0] DATA_ADDR = 32'h4005_0000;
  localparam logic [31:0] MODEM_ADDR = 32'h4005_0014;
  localparam logic [31:0] FIFO_ADDR = 32'h4005_0018;
  localparam logic [31:0] IRQ_STAT_ADDR = 32'h4005_0020;
  localparam logic [31:0] IRQ_CLR_ADDR = 32'h4005_0024;
  localparam logic [31:0] IRQ_EN_ADDR = 32'h4005_0028;
  localparam int CTS_FLAG_BIT = 0;
  localparam int CTS_LEVEL_BIT = 4;
  localparam int CTS_POL_BIT = 8;
  localparam int RX_EMPTY_BIT = 14;
  localparam int LEVEL_LSB = 16;
  localparam int TX_EMPTY_BIT = 22;
  localparam int TX_FULL_BIT = 23;
  localparam int TX_OVF_BIT = 24;
  localparam int TX_IDLE_BIT = 28;
  localparam int MODEM_IRQ_BIT = 0;
  localparam int BUF_IRQ_BIT = 1;
  localparam logic [31:0] FIFO_RESET = 32'h1040_4000;
  localparam logic CTS_POL_RESET = 1'b0;
  localparam logic CTS_PIN_RESET = 1'b1;
  localparam logic [1:0] IRQ_EN_RESET = 2'h0;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
  localparam int LEVEL_W = 6;
  localparam int CLK_HZ = 10_000_000;
  localparam int BAUD_HZ = 115200;
  localparam int BIT_CYCLES = CLK_HZ / BAUD_HZ;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    TX_IDLE = 2'h0,
    TX_START = 2'h1,
    TX_DATA = 2'h3,
    TX_STOP = 2'h2
  } umfs_tx_state_type;
endpackage

// ===== hw/umfs_tx_fifo.sv
`timescale 1ns/10ps
module umfs_tx_fifo (
  input wire logic clk_in, // core clock
  input wire logic reset_n_in, // async reset, active low
  input wire logic push_in, // write one byte
  input wire logic [7:0] push_data_in, // byte to write
  input wire logic pop_in, // take one byte
  output logic [7:0] pop_data_out, // oldest byte
  output logic [umfs_pkg::LEVEL_W-1:0] level_out, // bytes held
  output logic full_out, // no room
  output logic empty_out // nothing held
);
  logic [7:0] mem [umfs_pkg::FIFO_DEPTH];
  logic [umfs_pkg::FIFO_AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [umfs_pkg::LEVEL_W-1:0] level, next_level;
  logic do_push, do_pop;

  always_comb begin
    do_push = push_in && (level != umfs_pkg::LEVEL_W'(umfs_pkg::FIFO_DEPTH));
    do_pop = pop_in && (level != '0);
    next_wr_ptr = do_push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = do_pop ? rd_ptr + 1'b1 : rd_ptr;
    // [RULE14] level tracks pushes and pops
    next_level = level;
    if (do_push && !do_pop) begin
      next_level = level + 1'b1;
    end else if (do_pop && !do_push) begin
      next_level = level - 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      level <= next_level;
    end
  end

  // storage has no reset: the head slot at rd_ptr is always driven out, but only taken while the level is nonzero
  always_ff @(posedge clk_in) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data_in;
    end
  end

  assign pop_data_out = mem[rd_ptr];
  assign level_out = level;
  assign full_out = (level == umfs_pkg::LEVEL_W'(umfs_pkg::FIFO_DEPTH));
  assign empty_out = (level == '0);
endmodule

// ===== hw/umfs_tx_shifter.sv
`timescale 1ns/10ps
module umfs_tx_shifter (
  input wire logic clk_in, // core clock
  input wire logic reset_n_in, // async reset, active low
  input wire logic avail_in, // fifo holds a byte
  input wire logic [7:0] data_in, // byte at fifo head
  output logic pop_out, // byte taken this cycle
  output logic busy_out, // frame on the line, stop bit included
  output logic line_out // serial line, idle high
);
  localparam logic [7:0] LAST_TICK = 8'(umfs_pkg::BIT_CYCLES - 1);
  umfs_pkg::umfs_tx_state_type state, next_state;
  logic [7:0] div_cnt, next_div_cnt, shreg, next_shreg;
  logic [2:0] bit_idx, next_bit_idx;
  logic line, next_line, tick;

  always_comb begin
    tick = (div_cnt == LAST_TICK);
    next_state = state;
    next_shreg = shreg;
    next_bit_idx = bit_idx;
    next_line = line;
    pop_out = 1'b0;
    next_div_cnt = (state == umfs_pkg::TX_IDLE || tick) ? 8'h00 : div_cnt + 8'h01;
    unique case (state)
      umfs_pkg::TX_IDLE: begin
        if (avail_in) begin
          pop_out = 1'b1;
          next_shreg = data_in;
          next_line = 1'b0;
          next_state = umfs_pkg::TX_START;
        end
      end
      umfs_pkg::TX_START: begin
        if (tick) begin
          next_line = shreg[0];
          next_bit_idx = 3'h0;
          next_state = umfs_pkg::TX_DATA;
        end
      end
      umfs_pkg::TX_DATA: begin
        if (tick) begin
          if (bit_idx == 3'h7) begin
            next_line = 1'b1;
            next_state = umfs_pkg::TX_STOP;
          end else begin
            next_shreg = {1'b0, shreg[7:1]};
            next_line = shreg[1];
            next_bit_idx = bit_idx + 3'h1;
          end
        end
      end
      umfs_pkg::TX_STOP: begin
        if (tick) begin
          next_state = umfs_pkg::TX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= umfs_pkg::TX_IDLE;
      div_cnt <= 8'h00;
      shreg <= 8'h00;
      bit_idx <= 3'h0;
      line <= 1'b1;
    end else begin
      state <= next_state;
      div_cnt <= next_div_cnt;
      shreg <= next_shreg;
      bit_idx <= next_bit_idx;
      line <= next_line;
    end
  end

  assign busy_out = (state != umfs_pkg::TX_IDLE);
  assign line_out = line;
endmodule

// ===== hw/umfs_status.sv
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/10ps
// Behaviour
// [RULE1] a control bit picks the clear-to-send polarity: 0 means low is asserted, 1 high.
// [RULE2] a read-only bit shows the present level of the clear-to-send pin.
// [RULE3] any change of the clear-to-send pin, either way, sets the change flag.
// [RULE4] the modem interrupt is high while the change flag and its enable are both set.
// [RULE5] the change and overflow flags clear only on a written 1; a written 0 does nothing.
// [RULE6] transmitter idle is set only when the fifo is empty and the last stop bit has gone.
// [RULE7] transmitter idle drops while the fifo holds data or a byte is still being sent.
// [RULE8] a data port write while the fifo is full sets the sticky overflow flag.
// [RULE9] overflow also raises the buffer-error event, which interrupts when enabled.
// [RULE10] the transmit-full bit is high exactly while the fifo is full.
// [RULE11] the fifo-empty bit sets once the last byte has moved into the shifter.
// [RULE12] the fifo-empty bit clears once software writes a byte into the fifo.
// [RULE13] after reset the fifo status register reads its reset value with the empty bits set.
// [RULE14] the fifo level rises on each write and falls on each move into the shifter.
// [RULE15] reserved bits of both status registers read zero and ignore writes.
module umfs_status (
  input wire logic core_clk_in, // 10 MHz clock
  input wire logic reset_n_in, // async reset, active low
  input wire logic [31:0] axi_awaddr_in, // write address
  input wire logic axi_awvalid_in, // write address valid
  output logic axi_awready_out, // write address ready
  input wire logic [31:0] axi_wdata_in, // write data
  input wire logic [3:0] axi_wstrb_in, // write byte strobes
  input wire logic axi_wvalid_in, // write data valid
  output logic axi_wready_out, // write data ready
  output logic [1:0] axi_bresp_out, // write response
  output logic axi_bvalid_out, // write response valid
  input wire logic axi_bready_in, // write response ready
  input wire logic [31:0] axi_araddr_in, // read address
  input wire logic axi_arvalid_in, // read address valid
  output logic axi_arready_out, // read address ready
  output logic [31:0] axi_rdata_out, // read data
  output logic [1:0] axi_rresp_out, // read response
  output logic axi_rvalid_out, // read data valid
  input wire logic axi_rready_in, // read data ready
  input wire logic cts_pin_in, // clear-to-send pin from the remote
  output logic cts_asserted_out, // clear-to-send seen as asserted
  output logic tx_line_out, // serial transmit line
  output logic irq_out // interrupt, active high level
);
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [31:0] awaddr_q, next_awaddr_q, wdata_q, next_wdata_q;
  logic [3:0] wstrb_q, next_wstrb_q;
  logic awready, next_awready, wready, next_wready, bvalid, next_bvalid;
  logic arready, next_arready, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic do_write, aw_fire, w_fire, ar_fire;
  logic cts_meta, cts_sync, cts_prev, cts_change;
  logic cts_polarity_select, next_cts_polarity_select;
  logic cts_change_flag, next_cts_change_flag;
  logic tx_overflow_flag, next_tx_overflow_flag;
  logic [1:0] irq_enable, next_irq_enable;
  logic cts_asserted, next_cts_asserted, irq, next_irq;
  logic clr_cts, clr_ovf, data_wr, push, overflow;
  logic tx_fifo_full, tx_fifo_empty, tx_busy, tx_pop, transmitter_idle_flag;
  logic [7:0] head_byte;
  logic [umfs_pkg::LEVEL_W-1:0] tx_fifo_level;

  function automatic logic lane_on(input logic [3:0] strb, input int bit_pos);
    lane_on = strb[bit_pos / 8];
  endfunction

  function automatic logic is_mapped(input logic [31:0] addr);
    is_mapped = (addr == umfs_pkg::DATA_ADDR) || (addr == umfs_pkg::MODEM_ADDR) ||
                (addr == umfs_pkg::FIFO_ADDR) || (addr == umfs_pkg::IRQ_STAT_ADDR) ||
                (addr == umfs_pkg::IRQ_CLR_ADDR) || (addr == umfs_pkg::IRQ_EN_ADDR);
  endfunction

  umfs_tx_fifo u_fifo (
    .clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .push_in(push),
    .push_data_in(wdata_q[7:0]),
    .pop_in(tx_pop),
    .pop_data_out(head_byte),
    .level_out(tx_fifo_level),
    .full_out(tx_fifo_full),
    .empty_out(tx_fifo_empty)
  );

  umfs_tx_shifter u_shift (
    .clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .avail_in(!tx_fifo_empty),
    .data_in(head_byte),
    .pop_out(tx_pop),
    .busy_out(tx_busy),
    .line_out(tx_line_out)
  );

  // bus slave: address and data may come in either order, write acts once both are held
  always_comb begin
    aw_fire = axi_awvalid_in && awready;
    w_fire = axi_wvalid_in && wready;
    ar_fire = axi_arvalid_in && arready;
    do_write = aw_held && w_held && !bvalid;
    next_aw_held = (aw_held || aw_fire) && !do_write;
    next_w_held = (w_held || w_fire) && !do_write;
    next_awaddr_q = aw_fire ? axi_awaddr_in : awaddr_q;
    next_wdata_q = w_fire ? axi_wdata_in : wdata_q;
    next_wstrb_q = w_fire ? axi_wstrb_in : wstrb_q;
    next_bvalid = do_write || (bvalid && !axi_bready_in);
    next_bresp = do_write ? (is_mapped(awaddr_q) ? umfs_pkg::RESP_OKAY :
                             umfs_pkg::RESP_SLVERR) : bresp;
    next_awready = !next_aw_held && !next_bvalid;
    next_wready = !next_w_held && !next_bvalid;
    next_rvalid = ar_fire || (rvalid && !axi_rready_in);
    next_arready = !next_rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (ar_fire) begin
      next_rresp = is_mapped(axi_araddr_in) ? umfs_pkg::RESP_OKAY : umfs_pkg::RESP_SLVERR;
      next_rdata = 32'h0000_0000;
      // [RULE15] reserved read zero
      unique case (axi_araddr_in)
        umfs_pkg::MODEM_ADDR: begin
          // [RULE2] live pin level
          next_rdata[umfs_pkg::CTS_LEVEL_BIT] = cts_sync;
          next_rdata[umfs_pkg::CTS_POL_BIT] = cts_polarity_select;
          next_rdata[umfs_pkg::CTS_FLAG_BIT] = cts_change_flag;
        end
        umfs_pkg::FIFO_ADDR: begin
          // [RULE13] rx side absent, so rx empty stays at its reset value
          next_rdata[umfs_pkg::RX_EMPTY_BIT] = umfs_pkg::FIFO_RESET[umfs_pkg::RX_EMPTY_BIT];
          // [RULE10] full bit live
          next_rdata[umfs_pkg::TX_FULL_BIT] = tx_fifo_full;
          // [RULE11] empty after last move
          next_rdata[umfs_pkg::TX_EMPTY_BIT] = tx_fifo_empty;
          next_rdata[umfs_pkg::LEVEL_LSB +: umfs_pkg::LEVEL_W] = tx_fifo_level;
          next_rdata[umfs_pkg::TX_OVF_BIT] = tx_overflow_flag;
          next_rdata[umfs_pkg::TX_IDLE_BIT] = transmitter_idle_flag;
        end
        umfs_pkg::IRQ_STAT_ADDR: begin
          next_rdata[umfs_pkg::MODEM_IRQ_BIT] = cts_change_flag;
          next_rdata[umfs_pkg::BUF_IRQ_BIT] = tx_overflow_flag;
        end
        umfs_pkg::IRQ_EN_ADDR: begin
          next_rdata[1:0] = irq_enable;
        end
        default: begin
          next_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= umfs_pkg::RESP_OKAY;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rresp <= umfs_pkg::RESP_OKAY;
      rdata <= 32'h0000_0000;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      awaddr_q <= next_awaddr_q;
      wdata_q <= next_wdata_q;
      wstrb_q <= next_wstrb_q;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  // status flags and control bits
  always_comb begin
    data_wr = do_write && (awaddr_q == umfs_pkg::DATA_ADDR) && wstrb_q[0];
    // [RULE12] a write fills the fifo
    push = data_wr && !tx_fifo_full;
    // [RULE8] write into full fifo
    overflow = data_wr && tx_fifo_full;
    // [RULE5] only a written 1 clears
    clr_cts = do_write && (((awaddr_q == umfs_pkg::MODEM_ADDR) &&
              lane_on(wstrb_q, umfs_pkg::CTS_FLAG_BIT) && wdata_q[umfs_pkg::CTS_FLAG_BIT]) ||
              ((awaddr_q == umfs_pkg::IRQ_CLR_ADDR) && wstrb_q[0] &&
              wdata_q[umfs_pkg::MODEM_IRQ_BIT]));
    clr_ovf = do_write && (((awaddr_q == umfs_pkg::FIFO_ADDR) &&
              lane_on(wstrb_q, umfs_pkg::TX_OVF_BIT) && wdata_q[umfs_pkg::TX_OVF_BIT]) ||
              ((awaddr_q == umfs_pkg::IRQ_CLR_ADDR) && wstrb_q[0] &&
              wdata_q[umfs_pkg::BUF_IRQ_BIT]));
    // [RULE3] either edge of the pin
    cts_change = (cts_sync != cts_prev);
    // a change in the clearing cycle wins, so no edge is lost
    next_cts_change_flag = cts_change || (cts_change_flag && !clr_cts);
    // [RULE9] overflow is the buffer-error event
    next_tx_overflow_flag = overflow || (tx_overflow_flag && !clr_ovf);
    next_cts_polarity_select = cts_polarity_select;
    if (do_write && (awaddr_q == umfs_pkg::MODEM_ADDR) &&
        lane_on(wstrb_q, umfs_pkg::CTS_POL_BIT)) begin
      next_cts_polarity_select = wdata_q[umfs_pkg::CTS_POL_BIT];
    end
    next_irq_enable = irq_enable;
    if (do_write && (awaddr_q == umfs_pkg::IRQ_EN_ADDR) && wstrb_q[0]) begin
      next_irq_enable = wdata_q[1:0];
    end
    // [RULE1] polarity steers the asserted sense
    next_cts_asserted = (cts_sync == cts_polarity_select);
    // [RULE4] modem and buffer-error sources share one line
    next_irq = (cts_change_flag && irq_enable[umfs_pkg::MODEM_IRQ_BIT]) ||
               (tx_overflow_flag && irq_enable[umfs_pkg::BUF_IRQ_BIT]);
    // [RULE6] [RULE7] idle needs both an empty fifo and a quiet shifter
    transmitter_idle_flag = tx_fifo_empty && !tx_busy;
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cts_meta <= umfs_pkg::CTS_PIN_RESET;
      cts_sync <= umfs_pkg::CTS_PIN_RESET;
      cts_prev <= umfs_pkg::CTS_PIN_RESET;
      cts_change_flag <= 1'b0;
      tx_overflow_flag <= 1'b0;
      cts_polarity_select <= umfs_pkg::CTS_POL_RESET;
      irq_enable <= umfs_pkg::IRQ_EN_RESET;
      cts_asserted <= 1'b0;
      irq <= 1'b0;
    end else begin
      cts_meta <= cts_pin_in;
      cts_sync <= cts_meta;
      cts_prev <= cts_sync;
      cts_change_flag <= next_cts_change_flag;
      tx_overflow_flag <= next_tx_overflow_flag;
      cts_polarity_select <= next_cts_polarity_select;
      irq_enable <= next_irq_enable;
      cts_asserted <= next_cts_asserted;
      irq <= next_irq;
    end
  end

  assign axi_awready_out = awready;
  assign axi_wready_out = wready;
  assign axi_bvalid_out = bvalid;
  assign axi_bresp_out = bresp;
  assign axi_arready_out = arready;
  assign axi_rvalid_out = rvalid;
  assign axi_rresp_out = rresp;
  assign axi_rdata_out = rdata;
  assign cts_asserted_out = cts_asserted;
  assign irq_out = irq;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  cts_polarity_a: assert property ( // [RULE1]
    cts_asserted_out == ($past(cts_sync) == $past(cts_polarity_select)))
    else $error("clear-to-send sense wrong");
  pin_level_read_a: assert property ( // [RULE2]
    (ar_fire && axi_araddr_in == umfs_pkg::MODEM_ADDR) |=>
    axi_rvalid_out && axi_rdata_out[umfs_pkg::CTS_LEVEL_BIT] == $past(cts_sync))
    else $error("pin level readback wrong");
  cts_change_a: assert property ( // [RULE3]
    (cts_sync != cts_prev) |=> cts_change_flag)
    else $error("pin change missed");
  modem_irq_a: assert property ( // [RULE4]
    (cts_change_flag && irq_enable[0]) |=> irq_out)
    else $error("modem interrupt missing");
  flag_clear_a: assert property ( // [RULE5]
    $fell(cts_change_flag) || $fell(tx_overflow_flag) |-> $past(clr_cts) || $past(clr_ovf))
    else $error("flag cleared without a written one");
  idle_read_a: assert property ( // [RULE6]
    (ar_fire && axi_araddr_in == umfs_pkg::FIFO_ADDR) |=>
    axi_rdata_out[umfs_pkg::TX_IDLE_BIT] == ($past(tx_fifo_empty) && !$past(tx_busy)))
    else $error("transmitter idle wrong");
  idle_drop_a: assert property ( // [RULE7]
    push |=> !transmitter_idle_flag [*3])
    else $error("idle while data pending");
  // a frame may end in the overflow cycle, so the shifter can still take one byte
  overflow_set_a: assert property ( // [RULE8]
    (data_wr && tx_fifo_full) |=> tx_overflow_flag &&
    tx_fifo_level == $past(tx_fifo_level) - umfs_pkg::LEVEL_W'($past(tx_pop)))
    else $error("overflow not flagged");
  buf_irq_a: assert property ( // [RULE9]
    (tx_overflow_flag && irq_enable[1]) |=> irq_out)
    else $error("buffer error interrupt missing");
  full_bit_a: assert property ( // [RULE10]
    (ar_fire && axi_araddr_in == umfs_pkg::FIFO_ADDR) |=>
    axi_rdata_out[umfs_pkg::TX_FULL_BIT] ==
    ($past(tx_fifo_level) == umfs_pkg::LEVEL_W'(umfs_pkg::FIFO_DEPTH)))
    else $error("full bit wrong");
  empty_set_a: assert property ( // [RULE11]
    (tx_pop && tx_fifo_level == 6'h01 && !push) |=> tx_fifo_empty && tx_busy)
    else $error("empty not set after last move");
  empty_clear_a: assert property ( // [RULE12]
    push |=> !tx_fifo_empty)
    else $error("empty not cleared by write");
  level_count_a: assert property ( // [RULE14]
    (push && !tx_pop) |=> tx_fifo_level == $past(tx_fifo_level) + 6'h01)
    else $error("level not incremented");
  reserved_zero_a: assert property ( // [RULE15]
    rvalid |-> axi_rdata_out[31:29] == 3'h0 && axi_rdata_out[27:25] == 3'h0 &&
    axi_rdata_out[7:5] == 3'h0 && axi_rdata_out[3:2] == 2'h0)
    else $error("reserved bits nonzero");

  overflow_c: cover property (data_wr && tx_fifo_full);
  modem_irq_c: cover property (cts_change && irq_enable[0] ##2 irq_out);
  frame_done_c: cover property ($fell(tx_busy) && tx_fifo_empty);
  set_clear_race_c: cover property (cts_change && clr_cts);
endmodule

// ===== bench/umfs_cts_partner.sv
`timescale 1ns/10ps
// remote end: its clear-to-send line follows the wanted level after a lag
module umfs_cts_partner (
  input wire logic clk_in, // core clock
  input wire logic want_in, // level to drive next
  input wire logic [7:0] lag_in, // cycles before the line follows
  output logic cts_out // clear-to-send line
);
  logic [7:0] cnt;
  initial begin
    cts_out = 1'b1;
    cnt = 8'h00;
  end
  always @(posedge clk_in) begin
    if (want_in == cts_out) begin
      cnt <= 8'h00;
    end else if (cnt >= lag_in) begin
      cts_out <= want_in;
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule

// ===== bench/uart_modem_fifo_status_test.sv
`timescale 1ns/10ps
module uart_modem_fifo_status_test;
  logic clk, rst_n, awv, wv, bry, arv, rry, want;
  logic aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, cts_pin, cts_act, txl, irq;
  logic [31:0] awa, wd, ara, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  logic [3:0] ws;
  logic [7:0] lag;
  int error_cnt, n_checks;
  umfs_status u_dut (.core_clk_in(clk), .reset_n_in(rst_n), .axi_awaddr_in(awa),
    .axi_awvalid_in(awv), .axi_awready_out(aw_rdy), .axi_wdata_in(wd), .axi_wstrb_in(ws),
    .axi_wvalid_in(wv), .axi_wready_out(w_rdy), .axi_bresp_out(bresp), .axi_bvalid_out(b_vld),
    .axi_bready_in(bry), .axi_araddr_in(ara), .axi_arvalid_in(arv), .axi_arready_out(ar_rdy),
    .axi_rdata_out(rdata), .axi_rresp_out(rresp), .axi_rvalid_out(r_vld), .axi_rready_in(rry),
    .cts_pin_in(cts_pin), .cts_asserted_out(cts_act), .tx_line_out(txl), .irq_out(irq));
  umfs_cts_partner u_far (.clk_in(clk), .want_in(want), .lag_in(lag), .cts_out(cts_pin));
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: flag %b want %b", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // the leading edge keeps two transfers from touching a signal in one step
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (!ad && aw_rdy === 1'b1) begin
        ad = 1'b1;
        awv <= 1'b0;
      end
      if (!dd && w_rdy === 1'b1) begin
        dd = 1'b1;
        wv <= 1'b0;
      end
    end
    do @(posedge clk); while (b_vld !== 1'b1);
    rs = bresp;
    bry <= 1'b0;
  endtask
  task automatic axi_rd(input logic [31:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do @(posedge clk); while (ar_rdy !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (r_vld !== 1'b1);
    rd = rdata;
    rs = rresp;
    rry <= 1'b0;
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    axi_rd(a);
    chk32(rd, exp);
  endtask
  // status that settles only after whole frames is polled with a bound
  task automatic poll(input logic [31:0] a, input logic [31:0] exp);
    int k;
    k = 0;
    axi_rd(a);
    while (rd !== exp && k < 200) begin
      wt(100);
      axi_rd(a);
      k++;
    end
    chk32(rd, exp);
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    conclude();
  end
  initial begin
    {awv, wv, bry, arv, rry, rst_n} = 6'h00;
    {awa, wd, ara} = {3{32'h0000_0000}};
    ws = 4'hf;
    want = 1'b1;
    lag = 8'h00;
    error_cnt = 0;
    n_checks = 0;
    wt(4);
    rst_n <= 1'b1;
    rd_chk(umfs_pkg::FIFO_ADDR, umfs_pkg::FIFO_RESET);
    rd_chk(umfs_pkg::MODEM_ADDR, 32'h0000_0010);
    chk1(cts_act, 1'b0);
    chk1(txl, 1'b1);
    axi_wr(umfs_pkg::MODEM_ADDR, 32'hffff_fe00);
    rd_chk(umfs_pkg::MODEM_ADDR, 32'h0000_0010);
    axi_wr(umfs_pkg::FIFO_ADDR, 32'he1ff_ffff);
    rd_chk(umfs_pkg::FIFO_ADDR, umfs_pkg::FIFO_RESET);
    axi_wr(umfs_pkg::MODEM_ADDR, 32'h0000_0100);
    wt(2);
    chk1(cts_act, 1'b1);
    axi_wr(umfs_pkg::IRQ_EN_ADDR, 32'h0000_0001);
    want <= 1'b0;
    wt(10);
    rd_chk(umfs_pkg::MODEM_ADDR, 32'h0000_0101);
    chk1(irq, 1'b1);
    chk1(cts_act, 1'b0);
    axi_wr(umfs_pkg::MODEM_ADDR, 32'h0000_0100);
    rd_chk(umfs_pkg::MODEM_ADDR, 32'h0000_0101);
    axi_wr(umfs_pkg::MODEM_ADDR, 32'h0000_0101);
    rd_chk(umfs_pkg::MODEM_ADDR, 32'h0000_0100);
    chk1(irq, 1'b0);
    // low-active sense while the pin is held low
    axi_wr(umfs_pkg::MODEM_ADDR, 32'h0000_0000);
    wt(2);
    chk1(cts_act, 1'b1);
    rd_chk(umfs_pkg::MODEM_ADDR, 32'h0000_0000);
    lag <= 8'h14;
    want <= 1'b1;
    wt(40);
    rd_chk(umfs_pkg::IRQ_STAT_ADDR, 32'h0000_0001);
    axi_wr(umfs_pkg::IRQ_CLR_ADDR, 32'h0000_0001);
    rd_chk(umfs_pkg::IRQ_STAT_ADDR, 32'h0000_0000);
    axi_wr(umfs_pkg::IRQ_EN_ADDR, 32'h0000_0000);
    axi_rd(32'h4005_0030);
    chk32({30'h0, rs}, {30'h0, umfs_pkg::RESP_SLVERR});
    chk32(rd, 32'h0000_0000);
    axi_wr(umfs_pkg::DATA_ADDR, 32'h0000_00a5);
    wt(4);
    chk1(txl, 1'b0);
    rd_chk(umfs_pkg::FIFO_ADDR, 32'h0040_4000);
    poll(umfs_pkg::FIFO_ADDR, umfs_pkg::FIFO_RESET);
    for (int i = 0; i < 2; i++) axi_wr(umfs_pkg::DATA_ADDR, 32'h0000_0030 + i);
    wt(4);
    rd_chk(umfs_pkg::FIFO_ADDR, 32'h0001_4000);
    for (int i = 0; i < 15; i++) axi_wr(umfs_pkg::DATA_ADDR, 32'h0000_0040 + i);
    rd_chk(umfs_pkg::FIFO_ADDR, 32'h0090_4000);
    axi_wr(umfs_pkg::DATA_ADDR, 32'h0000_00ee);
    rd_chk(umfs_pkg::FIFO_ADDR, 32'h0190_4000);
    rd_chk(umfs_pkg::IRQ_STAT_ADDR, 32'h0000_0002);
    chk1(irq, 1'b0);
    axi_wr(umfs_pkg::IRQ_EN_ADDR, 32'h0000_0002);
    wt(2);
    chk1(irq, 1'b1);
    axi_wr(umfs_pkg::FIFO_ADDR, 32'h0000_0000);
    rd_chk(umfs_pkg::FIFO_ADDR, 32'h0190_4000);
    axi_wr(umfs_pkg::FIFO_ADDR, 32'h0100_0000);
    rd_chk(umfs_pkg::FIFO_ADDR, 32'h0090_4000);
    wt(2);
    chk1(irq, 1'b0);
    poll(umfs_pkg::FIFO_ADDR, 32'h000f_4000);
    // fifteen whole frames and the rest of the one in flight drain here, hence the long poll bound
    poll(umfs_pkg::FIFO_ADDR, umfs_pkg::FIFO_RESET);
    conclude();
  end
endmodule
